/* verilog/vfw_resp.sv */
/*
 Output overvoltage fault response, restart sequencing and output
 voltage warning thresholds, with their command port and status.
 Assumes the command port is fed by the bus engine on clk_i, and the
 sense and setpoint words come from logic on clk_i.
*/
`timescale 1ns/100ps
`include "vfw_defs.svh"
module vfw_resp #(
   parameter int TMR_W = 20
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Command port
   input  wire logic             cmd_valid_i,
   input  wire logic             cmd_write_i,
   input  wire logic             cmd_word_i,
   input  wire vfw_pkg::vfw_byte_t cmd_code_i,
   input  wire vfw_pkg::vfw_word_t cmd_wdata_i,
   output      logic             rd_valid_o,
   output      vfw_pkg::vfw_word_t rd_data_o,
   // Converter side
   input  wire logic             enable_i,
   input  wire logic             ov_fault_i,
   input  wire logic             vout_mode_abs_i,
   input  wire vfw_pkg::vfw_word_t vout_command_i,
   input  wire vfw_pkg::vfw_word_t vsense_i,
   input  wire vfw_pkg::vfw_word_t ton_rise_i,
   input  wire vfw_pkg::vfw_word_t ton_max_i,
   output      logic             conv_on_o,
   output      logic             latched_off_o,
   output      logic             alert_n_o
);
   import vfw_pkg::*;

   generate
      if (TMR_W < 19)
         $error("TMR_W must hold seven rise times");
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree
   logic [1:0] pin_raw;
   logic [1:0] pin_q;
   assign pin_raw = {enable_i, ov_fault_i};

   for (genvar g = 0; g < 2; g++)
   begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic q;
      always_ff @(posedge clk_i or posedge rst_i)
      begin
         if (rst_i)
         begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q  <= 1'b0;
         end
         else
         begin
            s1 <= pin_raw[g];
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
               q <= s3;
         end
      end
      assign pin_q[g] = q;
   end

   logic ov_now;
   logic en_q;
   assign ov_now = pin_q[0];
   assign en_q   = pin_q[1];

   ////////////////////////////////////////////////////////////////////
   // Tick divider
   logic [7:0] div;
   logic [7:0] next_div;
   logic       tick;
   assign tick = div == 8'(`VFW_TICK_CYC - 1);

   always_comb
   begin
      next_div = tick ? 8'h00 : div + 8'h01;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         div <= 8'h00;
      else
         div <= next_div;
   end

   ////////////////////////////////////////////////////////////////////
   // Limit to percent mapping; result is {valid, percent}
   function automatic logic [7:0] vfw_map(input vfw_word_t lim,
                                          input vfw_word_t refv,
                                          input logic      up);
      logic [23:0] l100;
      logic [6:0]  lo;
      logic [6:0]  hi;
      logic [6:0]  s;
      logic [7:0]  res;
      l100 = 24'(lim) * `VFW_PCT_SCALE;
      lo   = up ? `VFW_OV_PCT_MIN : `VFW_UV_PCT_MIN;
      hi   = up ? `VFW_OV_PCT_MAX : `VFW_UV_PCT_MAX;
      res  = 8'h00;
      for (int i = 0; i < `VFW_PCT_STEPS; i++)
      begin
         // Up walks downward so the smallest step covering wins
         s = up ? 7'(hi - 7'(i)) : 7'(lo + 7'(i));
         if (up ? (l100 <= 24'(refv) * 24'(s)) : (24'(refv) * 24'(s) <= l100))
            res = {1'b1, s};
      end
      if (refv == '0 || l100 < 24'(refv) * 24'(lo) || l100 > 24'(refv) * 24'(hi))
         res = 8'h00;
      return res;
   endfunction

   vfw_word_t map_ref;
   logic [7:0] ov_map;
   logic [7:0] uv_map;
   assign map_ref = vout_mode_abs_i ? vout_command_i : `VFW_REL_ONE;
   assign ov_map  = vfw_map(cmd_wdata_i, map_ref, 1'b1);
   assign uv_map  = vfw_map(cmd_wdata_i, map_ref, 1'b0);

   ////////////////////////////////////////////////////////////////////
   // Registers and status
   vfw_byte_t  ov_action;
   vfw_word_t  ov_warn_threshold;
   vfw_word_t  uv_warn_threshold;
   logic [6:0] ov_pct;
   logic [6:0] uv_pct;
   vfw_byte_t  st_vout;
   vfw_byte_t  st_cml;
   vfw_byte_t  next_action;
   vfw_word_t  next_ovw;
   vfw_word_t  next_uvw;
   logic [6:0] next_ov_pct;
   logic [6:0] next_uv_pct;
   vfw_byte_t  next_st_vout;
   vfw_byte_t  next_st_cml;
   vfw_word_t  next_rd_data;
   vfw_byte_t  st_byte;
   vfw_word_t  st_word;
   vfw_state_t state;
   logic [22:0] ov_level;
   logic [22:0] uv_level;
   logic        ov_warn_hit;
   logic        uv_warn_hit;

   assign ov_level    = 23'((24'(vout_command_i) * 24'(ov_pct)) / `VFW_PCT_SCALE);
   assign uv_level    = 23'((24'(vout_command_i) * 24'(uv_pct)) / `VFW_PCT_SCALE);
   assign ov_warn_hit = 23'(vsense_i) > ov_level;
   assign uv_warn_hit = state == VFW_ON && 23'(vsense_i) < uv_level;

   assign st_byte = {2'h0, st_vout[`VFW_SV_OVF], 3'h0, |st_cml,
                     |st_vout[`VFW_SV_OVW:0]};
   assign st_word = {|st_vout, 7'h00, st_byte};

   logic wr;
   logic rd;
   assign wr = cmd_valid_i && cmd_write_i;
   assign rd = cmd_valid_i && !cmd_write_i;

   always_comb
   begin
      vfw_byte_t set_v;
      vfw_byte_t set_c;
      vfw_byte_t clr_v;
      vfw_byte_t clr_c;
      set_v = 8'h00;
      set_c = 8'h00;
      clr_v = 8'h00;
      clr_c = 8'h00;
      next_action  = ov_action;
      next_ovw     = ov_warn_threshold;
      next_uvw     = uv_warn_threshold;
      next_ov_pct  = ov_pct;
      next_uv_pct  = uv_pct;
      next_rd_data = rd_data_o;
      set_v[`VFW_SV_OVF] = ov_now;
      set_v[`VFW_SV_OVW] = ov_warn_hit;
      set_v[`VFW_SV_UVW] = uv_warn_hit;
      if (cmd_valid_i)
      begin
         unique case (cmd_code_i)
            `VFW_CMD_OV_RESP:
            begin
               if (rd)
                  next_rd_data = {8'h00, ov_action};
               else if (cmd_word_i ||
                        cmd_wdata_i[`VFW_ACT_HI:`VFW_ACT_LO] == `VFW_ACT_BAD)
                  set_c[`VFW_CML_DATA] = 1'b1;
               else
                  next_action = cmd_wdata_i[7:0];
            end
            `VFW_CMD_OV_WARN:
            begin
               if (rd)
                  next_rd_data = ov_warn_threshold;
               else if (!cmd_word_i || !ov_map[7])
                  set_c[`VFW_CML_DATA] = 1'b1;
               else
               begin
                  next_ovw    = cmd_wdata_i;
                  next_ov_pct = ov_map[6:0];
               end
            end
            `VFW_CMD_UV_WARN:
            begin
               if (rd)
                  next_rd_data = uv_warn_threshold;
               else if (!cmd_word_i || !uv_map[7])
                  set_c[`VFW_CML_DATA] = 1'b1;
               else
               begin
                  next_uvw    = cmd_wdata_i;
                  next_uv_pct = uv_map[6:0];
               end
            end
            `VFW_CMD_ST_BYTE:
               next_rd_data = {8'h00, st_byte};
            `VFW_CMD_ST_WORD:
               next_rd_data = st_word;
            `VFW_CMD_ST_VOUT:
            begin
               next_rd_data = {8'h00, st_vout};
               clr_v = wr ? cmd_wdata_i[7:0] : 8'h00;
            end
            `VFW_CMD_ST_CML:
            begin
               next_rd_data = {8'h00, st_cml};
               clr_c = wr ? cmd_wdata_i[7:0] : 8'h00;
            end
            `VFW_CMD_CLEAR:
            begin
               next_rd_data = 16'h0000;
               clr_v = {8{wr}};
               clr_c = {8{wr}};
            end
            default:
            begin
               next_rd_data = 16'h0000;
               set_c[`VFW_CML_CMD] = 1'b1;
            end
         endcase
      end
      // Set wins over a clear in the same cycle
      next_st_vout = (st_vout & ~clr_v) | set_v;
      next_st_cml  = (st_cml & ~clr_c) | set_c;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ov_action         <= `VFW_RST_OV_RESP;
         ov_warn_threshold <= `VFW_RST_OV_WARN;
         uv_warn_threshold <= `VFW_RST_UV_WARN;
         ov_pct            <= `VFW_RST_OV_PCT;
         uv_pct            <= `VFW_RST_UV_PCT;
         st_vout           <= 8'h00;
         st_cml            <= 8'h00;
         rd_data_o         <= 16'h0000;
         rd_valid_o        <= 1'b0;
         alert_n_o         <= 1'b1;
      end
      else
      begin
         ov_action         <= next_action;
         ov_warn_threshold <= next_ovw;
         uv_warn_threshold <= next_uvw;
         ov_pct            <= next_ov_pct;
         uv_pct            <= next_uv_pct;
         st_vout           <= next_st_vout;
         st_cml            <= next_st_cml;
         rd_data_o         <= next_rd_data;
         rd_valid_o        <= rd;
         alert_n_o         <= !(|st_vout || |st_cml);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Start-up, shutdown and restart sequencer
   vfw_tmr_if #(.W(TMR_W)) tmr ();
   logic [2:0]  retry_cnt;
   logic [2:0]  next_retry;
   vfw_state_t  next_state;
   logic        act_shut;
   logic [2:0]  retry_lim;
   logic [2:0]  dly;
   logic [TMR_W-1:0] rise_wait;
   logic [TMR_W-1:0] restart_wait_period_len;

   vfw_timer u_tmr (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .t     (tmr.tmr)
   );

   assign tmr.tick  = tick;
   assign act_shut  = ov_action[`VFW_ACT_HI:`VFW_ACT_LO] != `VFW_ACT_IGNORE;
   assign retry_lim = ov_action[`VFW_RETRY_HI:`VFW_RETRY_LO];
   assign dly       = ov_action[`VFW_DELAY_HI:`VFW_DELAY_LO];
   // Rise window ends at the longer of rise and max-on time
   assign rise_wait = TMR_W'((ton_max_i > ton_rise_i) ? ton_max_i : ton_rise_i);
   assign restart_wait_period_len = TMR_W'(ton_rise_i) * TMR_W'((dly == 3'h0) ? 3'h1 : dly);

   always_comb
   begin
      logic shut;
      shut       = ov_now && act_shut;
      next_state = state;
      next_retry = retry_cnt;
      tmr.start  = 1'b0;
      tmr.load   = rise_wait;
      unique case (state)
         VFW_OFF:
            // No start into a standing fault
            if (en_q && !ov_now)
            begin
               next_state = VFW_RISE;
               tmr.start  = 1'b1;
            end
         VFW_RISE, VFW_VERIFY, VFW_ON:
            if (shut)
            begin
               // Latch or restart_wait_period by retry field
               if (retry_lim == `VFW_RETRY_LATCH ||
                   (retry_lim != `VFW_RETRY_FOREVR && retry_cnt >= retry_lim))
                  next_state = VFW_LATCHED;
               else
               begin
                  next_state = VFW_RESTART_WAIT_PERIOD;
                  tmr.start  = 1'b1;
                  tmr.load   = restart_wait_period_len;
               end
            end
            else if (state == VFW_RISE && tmr.done)
            begin
               next_state = VFW_VERIFY;
               tmr.start  = 1'b1;
               tmr.load   = TMR_W'(ton_rise_i);
            end
            else if (state == VFW_VERIFY && tmr.done)
            begin
               next_state = VFW_ON;
               next_retry = 3'h0;
            end
         VFW_RESTART_WAIT_PERIOD:
            if (tmr.done)
            begin
               next_state = VFW_RISE;
               tmr.start  = 1'b1;
               next_retry = (retry_cnt == 3'h7) ? retry_cnt : retry_cnt + 3'h1;
            end
         VFW_LATCHED:
            next_state = VFW_LATCHED;
      endcase
      if (!en_q)
      begin
         next_state = VFW_OFF;
         next_retry = 3'h0;
         tmr.start  = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state         <= VFW_OFF;
         retry_cnt     <= 3'h0;
         conv_on_o     <= 1'b0;
         latched_off_o <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         retry_cnt     <= next_retry;
         conv_on_o     <= next_state inside {VFW_RISE, VFW_VERIFY, VFW_ON};
         latched_off_o <= next_state == VFW_LATCHED;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Assertions
   ov_flag_alert_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ov_now |-> ##1 (st_vout[`VFW_SV_OVF] && st_word[15] && st_byte[`VFW_SB_OVF])
                 ##1 !alert_n_o)
      else $error("overvoltage fault not flagged");
   ov_ignore_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == VFW_ON && en_q && ov_action[7:6] == 2'h0) |=> (state == VFW_ON && conv_on_o))
      else $error("ignore action stopped output");
   retry_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == VFW_ON && en_q && ov_now && ov_action[7:6] != 2'h0 && ov_action[5:3] == 3'h0)
      |=> state == VFW_LATCHED)
      else $error("retry zero did not latch off");
   bad_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && !cmd_word_i && cmd_code_i == `VFW_CMD_OV_RESP && cmd_wdata_i[7:6] == 2'h3)
      |=> (st_cml[`VFW_CML_DATA] && ov_action == $past(ov_action)) ##1 !alert_n_o)
      else $error("invalid response byte accepted");
   restart_ok_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == VFW_VERIFY && tmr.done && en_q && !ov_now)
      |=> (state == VFW_ON && retry_cnt == 3'h0))
      else $error("successful restart not recorded");
   start_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == VFW_OFF && ov_now) |=> (state == VFW_OFF && !conv_on_o))
      else $error("start-up into standing overvoltage");
   ov_warn_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ov_warn_hit |=> st_vout[`VFW_SV_OVW] ##1 !alert_n_o)
      else $error("overvoltage warning not flagged");
   ov_pct_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ov_pct >= `VFW_OV_PCT_MIN && ov_pct <= `VFW_OV_PCT_MAX)
      else $error("overvoltage warning percent out of range");
   uv_warn_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      uv_warn_hit |=> st_vout[`VFW_SV_UVW] && st_word[15])
      else $error("undervoltage warning not flagged");
   uv_pct_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
      uv_pct >= `VFW_UV_PCT_MIN && uv_pct <= `VFW_UV_PCT_MAX)
      else $error("undervoltage warning percent out of range");
   word_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!wr && $changed(vout_command_i)) |=> $stable(ov_warn_threshold))
      else $error("limit word changed without a write");
   resp_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && !cmd_word_i && cmd_code_i == `VFW_CMD_OV_RESP && cmd_wdata_i[7:6] != 2'h3)
      |=> ov_action == $past(cmd_wdata_i[7:0]))
      else $error("response byte not applied");
   retry_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state == VFW_RESTART_WAIT_PERIOD && tmr.done && en_q && retry_cnt != 3'h7)
      |=> (state == VFW_RISE && retry_cnt == $past(retry_cnt) + 3'h1))
      else $error("restart attempt not counted");
endmodule // vfw_resp

/* inc/vfw_defs.svh */
/*
 Constants of the output-voltage fault and warning response block:
 command codes, field positions, reset values, status bits, timing.
 Assumes inclusion by bare name from design files.
*/
`ifndef VFW_DEFS_SVH
`define VFW_DEFS_SVH

// Command codes
`define VFW_CMD_CLEAR    8'h03
`define VFW_CMD_OV_RESP  8'h41
`define VFW_CMD_OV_WARN  8'h42
`define VFW_CMD_UV_WARN  8'h43
`define VFW_CMD_ST_BYTE  8'h78
`define VFW_CMD_ST_WORD  8'h79
`define VFW_CMD_ST_VOUT  8'h7a
`define VFW_CMD_ST_CML   8'h7e

// Fault response byte fields
`define VFW_ACT_HI       7
`define VFW_ACT_LO       6
`define VFW_RETRY_HI     5
`define VFW_RETRY_LO     3
`define VFW_DELAY_HI     2
`define VFW_DELAY_LO     0
`define VFW_ACT_IGNORE   2'h0
`define VFW_ACT_BAD      2'h3
`define VFW_RETRY_LATCH  3'h0
`define VFW_RETRY_FOREVR 3'h7

// Reset values
`define VFW_RST_OV_RESP  8'h80
`define VFW_RST_OV_WARN  16'h0238
`define VFW_RST_UV_WARN  16'h01c0
`define VFW_RST_OV_PCT   7'h6f
`define VFW_RST_UV_PCT   7'h57

// Threshold mapping, percent of commanded output
`define VFW_OV_PCT_MIN   7'h67
`define VFW_OV_PCT_MAX   7'h74
`define VFW_UV_PCT_MIN   7'h54
`define VFW_UV_PCT_MAX   7'h61
`define VFW_PCT_STEPS    14
`define VFW_PCT_SCALE    24'h000064
`define VFW_REL_ONE      16'h0200

// Status bit positions
`define VFW_SV_OVF       7
`define VFW_SV_OVW       6
`define VFW_SV_UVW       5
`define VFW_CML_CMD      7
`define VFW_CML_DATA     6
`define VFW_SB_OVF       5
`define VFW_SB_CML       1
`define VFW_SB_NOTA      0

// Timing: one tick per microsecond of rise-time units
`define VFW_CLK_NS       4
`define VFW_TICK_NS      1000
`define VFW_TICK_CYC     (`VFW_TICK_NS / `VFW_CLK_NS)

`endif

/* inc/vfw_pkg.sv */
/*
 Types of the output-voltage fault and warning response block.
 Assumes nothing beyond the compile order.
*/
package vfw_pkg;
   typedef logic [15:0] vfw_word_t;
   typedef logic [7:0]  vfw_byte_t;
   typedef enum logic [2:0] {
      VFW_OFF, VFW_RISE, VFW_VERIFY, VFW_ON, VFW_RESTART_WAIT_PERIOD, VFW_LATCHED
   } vfw_state_t;
endpackage

/* inc/vfw_tmr_if.sv */
/*
 Carrier between the response sequencer and its interval timer.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface vfw_tmr_if #(parameter int W = 20);
   logic         start;
   logic [W-1:0] load;
   logic         tick;
   logic         done;
   modport ctl (output start, output load, output tick, input done);
   modport tmr (input start, input load, input tick, output done);
endinterface

/* verilog/vfw_timer.sv */
/*
 Interval timer counting tick enables down from a loaded value.
 Assumes start is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/100ps
module vfw_timer (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Sequencer side
   vfw_tmr_if.tmr    t
);
   logic [$bits(t.load)-1:0] cnt;
   logic [$bits(t.load)-1:0] next_cnt;
   logic                     run;
   logic                     next_run;

   always_comb
   begin
      next_cnt = cnt;
      next_run = run;
      if (t.start)
      begin
         next_cnt = t.load;
         next_run = 1'b1;
      end
      else if (t.tick && cnt != '0)
         next_cnt = cnt - 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt <= '0;
         run <= 1'b0;
      end
      else
      begin
         cnt <= next_cnt;
         run <= next_run;
      end
   end

   // Stays high until the next start
   assign t.done = run && cnt == '0;
endmodule // vfw_timer

/* sim/vfw_host_model.sv */
/*
 Host model on the command port of the fault response block.
 Assumes answers to reads arrive within three clock cycles.
*/
`timescale 1ns/100ps
module vfw_host_model (
   // Clock and answer
   input  wire logic        clk_i,
   input  wire logic        rd_valid_i,
   input  wire logic [15:0] rd_data_i,
   // Request
   output      logic        cmd_valid_o,
   output      logic        cmd_write_o,
   output      logic        cmd_word_o,
   output      logic [7:0]  cmd_code_o,
   output      logic [15:0] cmd_wdata_o
);
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_word_o  = 1'b0;
      cmd_code_o  = 8'h00;
      cmd_wdata_o = 16'h0000;
   end
   task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                       input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b1;
      cmd_write_o = w;
      cmd_word_o  = wd;
      cmd_code_o  = c;
      cmd_wdata_o = d;
      @(posedge clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_code_o  = ~c;
      cmd_wdata_o = ~d;
      q = 16'hdead;
      repeat (3)
      begin
         if (!w && rd_valid_i === 1'b1)
         begin
            q = rd_data_i;
            break;
         end
         @(posedge clk_i);
         #1;
      end
   endtask
endmodule // vfw_host_model

/* sim/vfw_resp_tb_top.sv */
/*
 Self-checking bench for the fault response block.
 Assumes the host model issues commands; converter pins driven here.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module vfw_resp_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cv, cw, cwd, rv, con, lat, aln;
   logic [7:0]  cc;
   logic [15:0] cd, rdd;
   logic        en = 1'b0;
   logic        ovf = 1'b0;
   logic        abs = 1'b0;
   logic [15:0] vcmd = 16'd1000;
   logic [15:0] vsen = 16'd1000;
   int          mismatches = 0;
   int          checks_done = 0;
   int          rises = 0;
   int          lows = 0;
   logic [15:0] tmax = 16'h0000;
   always #2 clk_i = ~clk_i;
   always @(posedge con) rises++;
   vfw_host_model host (.clk_i(clk_i), .rd_valid_i(rv), .rd_data_i(rdd), .cmd_valid_o(cv),
      .cmd_write_o(cw), .cmd_word_o(cwd), .cmd_code_o(cc), .cmd_wdata_o(cd));
   vfw_resp #(.TMR_W(20)) uut (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cv),
      .cmd_write_i(cw), .cmd_word_i(cwd), .cmd_code_i(cc), .cmd_wdata_i(cd),
      .rd_valid_o(rv), .rd_data_o(rdd), .enable_i(en), .ov_fault_i(ovf),
      .vout_mode_abs_i(abs), .vout_command_i(vcmd), .vsense_i(vsen),
      .ton_rise_i(16'h0002), .ton_max_i(tmax), .conv_on_o(con),
      .latched_off_o(lat), .alert_n_o(aln));
   task automatic rd(input logic [7:0] c, input logic w, input logic [15:0] m, e);
      logic [15:0] q;
      host.xfer(1'b0, w, c, 16'h0000, q);
      `CHK(q & m, e)
   endtask
   task automatic wr(input logic [7:0] c, input logic w, input logic [15:0] d);
      logic [15:0] q;
      host.xfer(1'b1, w, c, d, q);
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic test_done;
      if (mismatches == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      step(8);
      rst_i = 1'b0;
      step(4);
      rd(8'h41, 0, 16'hffff, 16'h0080);
      rd(8'h42, 1, 16'hffff, 16'h0238);
      rd(8'h43, 1, 16'hffff, 16'h01c0);
      `CHK(aln, 1'b1)
      wr(8'h41, 0, 16'h00c0);
      rd(8'h41, 0, 16'hffff, 16'h0080);
      rd(8'h7e, 0, 16'h0040, 16'h0040);
      `CHK(aln, 1'b0)
      wr(8'h42, 1, 16'h01f4);
      rd(8'h42, 1, 16'hffff, 16'h0238);
      wr(8'h03, 0, 16'h0000);
      wr(8'h42, 1, 16'h0210);
      rd(8'h42, 1, 16'hffff, 16'h0210);
      vsen = 16'd1040;
      step(3);
      rd(8'h7a, 0, 16'hffff, 16'h0000);
      vsen = 16'd1041;
      step(3);
      rd(8'h7a, 0, 16'hffff, 16'h0040);
      rd(8'h79, 1, 16'h8000, 16'h8000);
      vsen = 16'd1000;
      wr(8'h03, 0, 16'h0000);
      wr(8'h43, 1, 16'h01e0);
      en = 1'b1;
      step(1100);
      vsen = 16'd931;
      step(3);
      rd(8'h7a, 0, 16'hffff, 16'h0000);
      vsen = 16'd929;
      step(3);
      rd(8'h7a, 0, 16'hffff, 16'h0020);
      vcmd = 16'd2000;
      vsen = 16'd2000;
      wr(8'h03, 0, 16'h0000);
      vsen = 16'd1859;
      step(3);
      rd(8'h7a, 0, 16'hffff, 16'h0020);
      vsen = 16'd2000;
      abs = 1'b1;
      wr(8'h43, 1, 16'h0708);
      vcmd = 16'd1900;
      rd(8'h43, 1, 16'hffff, 16'h0708);
      wr(8'h51, 0, 16'h0000);
      rd(8'h7e, 0, 16'h0080, 16'h0080);
      wr(8'h41, 0, 16'h0053);
      rd(8'h41, 0, 16'hffff, 16'h0053);
      rises = 0;
      ovf = 1'b1;
      for (int i = 0; i < 5000 && lat !== 1'b1; i++)
      begin
         step(1);
         if (con === 1'b0)
            lows++;
      end
      `CHK(lat, 1'b1)
      // Two hiccups of three rise times, each two ticks of 250 cycles
      `CHK(lows >= 2500 && lows <= 3004, 1'b1)
      `CHK(rises, 2)
      `CHK(con, 1'b0)
      rd(8'h78, 0, 16'h0020, 16'h0020);
      rd(8'h7a, 0, 16'h0080, 16'h0080);
      `CHK(aln, 1'b0)
      en = 1'b0;
      wr(8'h41, 0, 16'h0000);
      en = 1'b1;
      step(1100);
      `CHK(con, 1'b0)
      ovf = 1'b0;
      tmax = 16'h0003;
      step(10);
      `CHK(con, 1'b1)
      // Rise window stretched by the max-on time before reaching on
      step(1300);
      ovf = 1'b1;
      step(10);
      `CHK(con, 1'b1)
      `CHK(lat, 1'b0)
      wr(8'h41, 0, 16'h0080);
      step(10);
      `CHK(lat, 1'b1)
      `CHK(con, 1'b0)
      test_done();
   end
   initial
   begin
      #200000;
      mismatches++;
      test_done();
   end
endmodule // vfw_resp_tb_top
